// File: design/adc_acquisition_sequencer.sv
// Acquisition and conversion sequencer for a 10-bit SAR converter,
// with an AXI4-Lite register slave. The analog core answers each trial
// code within one clock; sleep comes from the power manager, unsynchronised.
// Functional notes
// - Format bit: one right, zero left justify
// - Acquisition field picks 0 to 20 bit periods
// - Clock field picks divider or RC clock
// - RC clock starts one instruction cycle late
// - Bit six unused, always reads zero
// - Only RC clock keeps converting in sleep
// - Successive approximation resolves 1024 levels
// - Reset restores registers, stops module, aborts conversion
// - Completion loads result, clears busy, sets flag
// - Result pair untouched by reset, unknown
// - Two bit periods wait before next acquisition
// - Nonzero setting acquires, then converts automatically
// - Zero setting converts at once; software times acquisition
// - After conversion sampling resumes on channel
// - Busy stays set through acquisition and conversion
// - Busy reads one while acquiring or converting
// - Enable bit turns the converter on
// - A conversion lasts eleven bit periods
// - Clearing go aborts; result keeps old value
`timescale 1ns/10ps
module adc_acquisition_sequencer
   import adc_seq_pkg::*;
(
   input wire logic clock, // System clock, 100 MHz
   input wire logic sys_rst, // Synchronous reset, high
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte enables
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic sleepIn, // Device sleep request, async
   input wire logic cmpIn, // Comparator: input above trial, async
   output logic sampleEn, // Hold capacitor tracks the input
   output logic [9:0] dacCode // Trial code for the comparator
);
   import adc_seq_pkg::*;

   typedef struct packed {
      seq_state_t st;
      logic on;
      logic [7:0] tim;
      logic flag;
      logic [9:0] res;
      logic [9:0] trial;
      logic [4:0] cnt;
      logic awHeld;
      logic [7:0] awAddr;
      logic wHeld;
      logic [7:0] wData;
      logic wLane0;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [7:0] rData;
      logic [1:0] rResp;
      logic [1:0] slp;
      logic cmp;
   } seq_reg_t;

   seq_reg_t s_q, s_d;
   tad_if tadBus ();

   logic awTake, wTake, arTake, haveAw, haveW, doWrite;
   logic [7:0] wrAddr, wrData;
   logic wrLane0, tick, goBusy, cmpS;
   logic [2:0] acqSel;

   tad_clock_gen tadGen (
      .clock(clock),
      .sys_rst(sys_rst),
      .t(tadBus)
   );

   // Byte of the result pair as placed by the format bit
   function automatic logic [7:0] resultByte(input logic [9:0] r, input logic rj,
      input logic hi);
      if (rj) begin
         resultByte = hi ? {6'h00, r[9:8]} : r[7:0];
      end else begin
         resultByte = hi ? r[9:2] : {r[1:0], 6'h00};
      end
   endfunction

   function automatic logic isMapped(input logic [7:0] a);
      isMapped = (a == ADDR_CTRL) || (a == ADDR_TIMING) || (a == ADDR_RES_HI) ||
         (a == ADDR_RES_LO) || (a == ADDR_STATUS);
   endfunction

   assign goBusy = (s_q.st == ST_ACQ) || (s_q.st == ST_CONV);
   assign acqSel = s_q.tim[ACQ_LSB +: 3];
   assign cmpS = s_q.cmp;
   assign tick = tadBus.tick;
   assign tadBus.clkSel = s_q.tim[CLKSEL_LSB +: 3];
   assign tadBus.run = goBusy || (s_q.st == ST_HOLD);
   assign tadBus.sleep = s_q.slp[1];

   // Address and data may arrive in either order; one write in flight
   assign s_axi_awready = !s_q.awHeld && !s_q.bValid;
   assign s_axi_wready = !s_q.wHeld && !s_q.bValid;
   assign s_axi_arready = !s_q.rValid;
   assign awTake = s_axi_awvalid && s_axi_awready;
   assign wTake = s_axi_wvalid && s_axi_wready;
   assign arTake = s_axi_arvalid && s_axi_arready;
   assign haveAw = s_q.awHeld || awTake;
   assign haveW = s_q.wHeld || wTake;
   assign doWrite = haveAw && haveW;
   assign wrAddr = s_q.awHeld ? s_q.awAddr : s_axi_awaddr;
   assign wrData = s_q.wHeld ? s_q.wData : s_axi_wdata[7:0];
   assign wrLane0 = s_q.wHeld ? s_q.wLane0 : s_axi_wstrb[0];

   assign s_axi_bvalid = s_q.bValid;
   assign s_axi_bresp = s_q.bResp;
   assign s_axi_rvalid = s_q.rValid;
   assign s_axi_rresp = s_q.rResp;
   assign s_axi_rdata = {24'h000000, s_q.rData};
   assign sampleEn = (s_q.st == ST_SAMPLE) || (s_q.st == ST_ACQ);
   assign dacCode = s_q.trial;

   always_comb begin
      logic [3:0] idx;
      logic [9:0] nt;
      logic doneSet;
      s_d = s_q;
      idx = 4'h0;
      nt = s_q.trial;
      doneSet = 1'b0;
      // Sleep is a foreign-domain pin and passes two flops
      s_d.slp = {s_q.slp[0], sleepIn};
      // The comparator answers our own registered trial code, so one capture
      // flop is enough; a second would miss the decision at clock/2
      s_d.cmp = cmpIn;

      // Register bus
      if (awTake) begin
         s_d.awHeld = 1'b1;
         s_d.awAddr = s_axi_awaddr;
      end
      if (wTake) begin
         s_d.wHeld = 1'b1;
         s_d.wData = s_axi_wdata[7:0];
         s_d.wLane0 = s_axi_wstrb[0];
      end
      if (s_q.bValid && s_axi_bready) begin
         s_d.bValid = 1'b0;
      end
      if (s_q.rValid && s_axi_rready) begin
         s_d.rValid = 1'b0;
      end
      if (arTake) begin
         s_d.rValid = 1'b1;
         s_d.rResp = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            ADDR_CTRL: s_d.rData = {6'h00, goBusy, s_q.on};
            ADDR_TIMING: s_d.rData = s_q.tim & TIMING_MASK;
            ADDR_RES_HI: s_d.rData = resultByte(s_q.res, s_q.tim[BIT_RJUST], 1'b1);
            ADDR_RES_LO: s_d.rData = resultByte(s_q.res, s_q.tim[BIT_RJUST], 1'b0);
            ADDR_STATUS: s_d.rData = {7'h00, s_q.flag};
            default: s_d.rData = 8'h00;
         endcase
      end

      if (doWrite) begin
         s_d.awHeld = 1'b0;
         s_d.wHeld = 1'b0;
         s_d.bValid = 1'b1;
         s_d.bResp = isMapped(wrAddr) ? RESP_OKAY : RESP_SLVERR;
      end

      // Sequencer
      case (s_q.st)
         ST_OFF: begin
            s_d.cnt = 5'h00;
         end
         ST_SAMPLE: begin
            s_d.cnt = 5'h00;
         end
         ST_ACQ: begin
            if (tick) begin
               s_d.cnt = s_q.cnt + 5'h01;
               if (s_q.cnt == acqTads(acqSel) - 5'h01) begin
                  s_d.st = ST_CONV;
                  s_d.cnt = 5'h00;
                  s_d.trial = SAR_FIRST;
               end
            end
         end
         ST_CONV: begin
            if (tick) begin
               s_d.cnt = s_q.cnt + 5'h01;
               // First period isolates the hold cap; then one bit per period
               if (s_q.cnt != 5'h00) begin
                  idx = 4'(5'd10 - s_q.cnt);
                  nt[idx] = cmpS;
                  if (idx != 4'h0) begin
                     nt[idx - 4'h1] = 1'b1;
                  end
                  s_d.trial = nt;
               end
               if (s_q.cnt == 5'(CONV_TADS - 1)) begin
                  s_d.res = nt;
                  s_d.flag = 1'b1;
                  doneSet = 1'b1;
                  s_d.st = ST_HOLD;
                  s_d.cnt = 5'h00;
               end
            end
         end
         ST_HOLD: begin
            if (tick) begin
               s_d.cnt = s_q.cnt + 5'h01;
               if (s_q.cnt == 5'(HOLDOFF_TADS - 1)) begin
                  s_d.st = ST_SAMPLE;
                  s_d.cnt = 5'h00;
               end
            end
         end
         default: begin
            s_d.st = ST_OFF;
         end
      endcase

      // Software writes come after the sequencer so an abort wins a tick
      if (doWrite && wrLane0) begin
         case (wrAddr)
            ADDR_CTRL: begin
               s_d.on = wrData[BIT_ON];
               if (!wrData[BIT_ON]) begin
                  s_d.st = ST_OFF;
               end else if (s_q.st == ST_OFF) begin
                  // Go in the same write that turns on is ignored
                  s_d.st = ST_SAMPLE;
               end else if (wrData[BIT_GO] && s_q.st == ST_SAMPLE) begin
                  s_d.cnt = 5'h00;
                  s_d.trial = SAR_FIRST;
                  if (acqSel == 3'h0) begin
                     s_d.st = ST_CONV;
                  end else begin
                     s_d.st = ST_ACQ;
                  end
               end else if (!wrData[BIT_GO] && goBusy) begin
                  s_d.st = ST_HOLD;
                  s_d.cnt = 5'h00;
                  s_d.res = s_q.res;
                  s_d.flag = s_q.flag;
               end
            end
            ADDR_TIMING: s_d.tim = wrData & TIMING_MASK;
            ADDR_STATUS: begin
               // A completion in this cycle keeps the flag set
               if (wrData[BIT_FLAG] && !doneSet) begin
                  s_d.flag = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.st <= ST_OFF;
         s_q.tim <= TIMING_RESET;
         s_q.res <= s_q.res;
      end else begin
         s_q <= s_d;
      end
   end

   sequence goWrite;
      doWrite && wrLane0 && wrAddr == ADDR_CTRL && wrData[BIT_GO] && wrData[BIT_ON];
   endsequence
   sequence convEnd;
      s_q.st == ST_CONV && tick && s_q.cnt == 5'd10;
   endsequence

   a_reset_off: assert property (@(posedge clock)
      sys_rst |=> s_q.st == ST_OFF && !s_q.on && s_q.tim == 8'h00)
      else $error("Reset did not switch the converter off");
   a_done_update: assert property (@(posedge clock) disable iff (sys_rst)
      convEnd |=> s_q.flag && !goBusy && s_q.st == ST_HOLD)
      else $error("Completion did not set flag and clear busy");
   a_manual_start: assert property (@(posedge clock) disable iff (sys_rst)
      goWrite ##0 (s_q.st == ST_SAMPLE && acqSel == 3'h0) |=> s_q.st == ST_CONV)
      else $error("Manual mode did not convert at once");
   a_auto_acq: assert property (@(posedge clock) disable iff (sys_rst)
      goWrite ##0 (s_q.st == ST_SAMPLE && acqSel != 3'h0) |=> goBusy && s_q.st == ST_ACQ)
      else $error("Programmed acquisition did not start");
   a_abort_keep: assert property (@(posedge clock) disable iff (sys_rst)
      doWrite && wrLane0 && wrAddr == ADDR_CTRL && wrData[BIT_ON] && !wrData[BIT_GO]
      && goBusy |=> $stable(s_q.res) && s_q.st == ST_HOLD)
      else $error("Abort changed the result");
   a_holdoff_len: assert property (@(posedge clock) disable iff (sys_rst)
      s_q.st == ST_SAMPLE && $past(s_q.st) == ST_HOLD |-> $past(tick)
      && $past(s_q.cnt) == 5'd1)
      else $error("Hold-off shorter than two bit periods");
   a_conv_len: assert property (@(posedge clock) disable iff (sys_rst)
      s_q.st == ST_HOLD && $past(s_q.st) == ST_CONV && !$past(doWrite)
      |-> $past(s_q.cnt) == 5'd10)
      else $error("Conversion not eleven bit periods");
   a_reserved_zero: assert property (@(posedge clock) disable iff (sys_rst)
      arTake && s_axi_araddr == ADDR_TIMING |=> s_axi_rvalid && !s_axi_rdata[6])
      else $error("Unused timing bit read as one");
   a_justify_hi: assert property (@(posedge clock) disable iff (sys_rst)
      arTake && s_axi_araddr == ADDR_RES_HI && s_q.tim[7] |=> s_axi_rdata[7:2] == 6'h00)
      else $error("Right-justified high byte not zero padded");
   a_off_idle: assert property (@(posedge clock) disable iff (sys_rst)
      !s_q.on |-> s_q.st == ST_OFF && !sampleEn)
      else $error("Converter active while switched off");
   a_sample_resume: assert property (@(posedge clock) disable iff (sys_rst)
      s_q.st == ST_HOLD && tick && s_q.cnt == 5'd1 && !doWrite |=> sampleEn)
      else $error("Sampling did not resume after hold-off");
   a_trial_live: assert property (@(posedge clock) disable iff (sys_rst)
      s_q.st == ST_CONV |-> dacCode != 10'h000)
      else $error("Trial code empty during conversion");
   a_first_trial: assert property (@(posedge clock) disable iff (sys_rst)
      s_q.st == ST_CONV && $past(s_q.st) != ST_CONV |-> dacCode == SAR_FIRST)
      else $error("Conversion did not start at mid-scale");
   a_busy_read: assert property (@(posedge clock) disable iff (sys_rst)
      arTake && s_axi_araddr == ADDR_CTRL
      |=> s_axi_rdata[1:0] == {$past(goBusy), $past(s_q.on)})
      else $error("Control read did not show busy and enable");
endmodule

// File: design/adc_seq_pkg.sv
// Shared constants, state codes and decoders for the converter sequencer.
// Assumes a 100 MHz system clock; register bus is 32-bit AXI4-Lite.
package adc_seq_pkg;
   localparam int CLK_PERIOD_NS = 10;
   // One instruction cycle, inserted before the RC bit clock starts
   localparam int INSTR_CYCLE_NS = 40;
   localparam int INSTR_CYCLES = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Private RC bit period stands in for the converter's own oscillator
   localparam int RC_TAD_NS = 1200;
   localparam int RC_DIV = RC_TAD_NS / CLK_PERIOD_NS;
   localparam int CONV_TADS = 11;
   localparam int HOLDOFF_TADS = 2;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_TIMING = 8'h04;
   localparam logic [7:0] ADDR_RES_HI = 8'h08;
   localparam logic [7:0] ADDR_RES_LO = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam int BIT_ON = 0;
   localparam int BIT_GO = 1;
   localparam int BIT_FLAG = 0;
   localparam int BIT_RJUST = 7;
   localparam int BIT_UNUSED = 6;
   localparam int ACQ_LSB = 3;
   localparam int CLKSEL_LSB = 0;
   localparam logic [7:0] TIMING_RESET = 8'h00;
   localparam logic [7:0] TIMING_MASK = 8'hbf;
   localparam logic [9:0] SAR_FIRST = 10'h200;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_SAMPLE = 3'b001,
      ST_ACQ = 3'b010,
      ST_CONV = 3'b011,
      ST_HOLD = 3'b100
   } seq_state_t;

   function automatic logic [4:0] acqTads(input logic [2:0] s);
      case (s)
         3'h7: acqTads = 5'd20;
         3'h6: acqTads = 5'd16;
         3'h5: acqTads = 5'd12;
         3'h4: acqTads = 5'd8;
         3'h3: acqTads = 5'd6;
         3'h2: acqTads = 5'd4;
         3'h1: acqTads = 5'd2;
         default: acqTads = 5'd0;
      endcase
   endfunction

   function automatic logic isRc(input logic [2:0] s);
      isRc = (s[1:0] == 2'b11);
   endfunction

   function automatic logic [6:0] tadDiv(input logic [2:0] s);
      case (s)
         3'h0: tadDiv = 7'd2;
         3'h1: tadDiv = 7'd8;
         3'h2: tadDiv = 7'd32;
         3'h4: tadDiv = 7'd4;
         3'h5: tadDiv = 7'd16;
         3'h6: tadDiv = 7'd64;
         default: tadDiv = 7'(RC_DIV);
      endcase
   endfunction
endpackage

// File: design/tad_if.sv
// Bit-period clock request and tick between sequencer and divider.
// Both ends run on the same system clock.
`timescale 1ns/10ps
interface tad_if;
   logic [2:0] clkSel;
   logic run;
   logic sleep;
   logic tick;
   modport gen (input clkSel, input run, input sleep, output tick);
   modport user (output clkSel, output run, output sleep, input tick);
endinterface

// File: design/tad_clock_gen.sv
// Divider that turns the system clock into bit-period ticks.
// Assumes sleep is already synchronised to the system clock.
`timescale 1ns/10ps
module tad_clock_gen
   import adc_seq_pkg::*;
(
   input wire logic clock, // System clock
   input wire logic sys_rst, // Synchronous reset, high
   tad_if.gen t // Bit-period request and tick
);
   typedef struct packed {
      logic [6:0] div;
      logic [2:0] dly;
      logic run;
   } gen_state_t;

   localparam logic [2:0] INSTR_DLY = 3'(INSTR_CYCLES);
   gen_state_t s_q, s_d;
   logic rc, runRise, stall;

   assign rc = isRc(t.clkSel);
   assign runRise = t.run && !s_q.run;
   // Only the RC source keeps running while the device sleeps
   assign stall = !t.run || (s_q.dly != 3'h0) || (runRise && rc) || (t.sleep && !rc);
   assign t.tick = !stall && (s_q.div == tadDiv(t.clkSel) - 7'd1);

   always_comb begin
      s_d = s_q;
      s_d.run = t.run;
      if (!t.run) begin
         s_d.div = 7'h00;
         s_d.dly = 3'h0;
      end else if (runRise && rc) begin
         s_d.dly = INSTR_DLY;
      end else if (s_q.dly != 3'h0) begin
         s_d.dly = s_q.dly - 3'h1;
      end else if (!stall) begin
         s_d.div = t.tick ? 7'h00 : s_q.div + 7'h01;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   a_rc_delay: assert property (@(posedge clock) disable iff (sys_rst)
      $rose(t.run) && isRc(t.clkSel) |-> !t.tick [*5])
      else $error("RC bit clock started without the instruction delay");
   a_sleep_stall: assert property (@(posedge clock) disable iff (sys_rst)
      t.sleep && !isRc(t.clkSel) |-> !t.tick)
      else $error("Oscillator bit clock ran during sleep");
   a_div_gap: assert property (@(posedge clock) disable iff (sys_rst)
      t.tick && !isRc(t.clkSel) && $stable(t.clkSel) ##1 t.run |-> !t.tick)
      else $error("Bit period shorter than two clocks");
endmodule

// File: tb/analog_core_model.sv
// Behavioural sample-and-hold and comparator facing the sequencer.
// Assumes level is held steady by the bench while a conversion runs.
`timescale 1ns/10ps
module analog_core_model (
   input wire logic clock, // System clock
   input wire logic sampleEn, // Hold capacitor tracks while high
   input wire logic [9:0] dacCode, // Trial code from the sequencer
   input wire logic [9:0] level, // Input in codes, plus half a code
   output logic cmp // High while held input is above the trial
);
   logic [9:0] held = 10'h000;

   always @(posedge clock) begin
      if (sampleEn) begin
         held <= level;
      end
   end

   // Half-code offset keeps every decision clear of a tie
   assign #1 cmp = ({held, 1'b1} > {dacCode, 1'b0});
endmodule

// File: tb/tb.sv
// Self-checking bench for the converter sequencer over AXI4-Lite.
// Assumes a 100 MHz clock and the analog core model on the far side.
`timescale 1ns/10ps
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin miscompares++; \
   $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
   import adc_seq_pkg::*;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic sleepIn = 1'b0, cmpIn, sampleEn, samplePrev = 1'b0;
   logic [9:0] dacCode, level = 10'h000;
   logic [31:0] seed = 32'h60;
   logic [15:0] prevRes;
   int cyc = 0, fallCyc = 0, lowLen = 0, miscompares = 0, checkCount = 0;
   int acqTab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
   int divTab[8] = '{2, 8, 32, RC_DIV, 4, 16, 64, RC_DIV};

   always #5 clock = ~clock;

   adc_acquisition_sequencer u_adc_acquisition_sequencer (.clock(clock), .sys_rst(sys_rst),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sleepIn(sleepIn),
      .cmpIn(cmpIn), .sampleEn(sampleEn), .dacCode(dacCode));

   analog_core_model u_analog_core_model (.clock(clock), .sampleEn(sampleEn),
      .dacCode(dacCode), .level(level), .cmp(cmpIn));

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", checkCount, miscompares);
      if (miscompares == 0 && checkCount > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Length of each low stretch of sampleEn: conversion plus hold-off
   always @(posedge clock) begin
      cyc <= cyc + 1;
      samplePrev <= sampleEn;
      if (samplePrev && !sampleEn) fallCyc <= cyc;
      if (!samplePrev && sampleEn) lowLen <= cyc - fallCyc;
      if (cyc == 60000) begin
         miscompares++;
         final_report();
      end
   end

   function automatic logic [31:0] nextRand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [15:0] expRes(input logic [9:0] v, input logic rj);
      return rj ? {6'h00, v[9:8], v[7:0]} : {v[9:2], v[1:0], 6'h00};
   endfunction

   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
         output logic [1:0] r);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clock);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 100);
      `CHK(s_axi_bvalid, 1'b1)
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clock);
   endtask

   task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clock);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 100);
      `CHK(s_axi_rvalid, 1'b1)
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clock);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axiWrite(a, d, 4'h1, r);
      `CHK(r, RESP_OKAY)
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axiRead(a, d, r);
      `CHK(r, RESP_OKAY)
      `CHK(d, e)
   endtask

   task automatic waitDone();
      logic [31:0] d;
      logic [1:0] r;
      int n;
      n = 0;
      do begin
         axiRead(ADDR_CTRL, d, r);
         n++;
      end while (d[BIT_GO] !== 1'b0 && n < 2000);
      `CHK(d[BIT_GO], 1'b0)
   endtask

   task automatic waitSampling();
      int n;
      n = 0;
      while (sampleEn !== 1'b1 && n < 2000) begin
         @(posedge clock);
         n++;
      end
      `CHK(sampleEn, 1'b1)
   endtask

   task automatic convert(input logic [2:0] cs, input logic [2:0] acq, input logic rj,
         input logic [9:0] v);
      int t0, dv, ac;
      dv = divTab[cs];
      ac = acqTab[acq];
      level <= v;
      wr(ADDR_TIMING, {24'h0, rj, 1'b1, acq, cs});
      rdChk(ADDR_TIMING, {24'h0, rj, 1'b0, acq, cs});
      t0 = cyc;
      wr(ADDR_CTRL, 32'h3);
      waitDone();
      `CHK((fallCyc - t0 >= ac * dv - dv) && (fallCyc - t0 <= ac * dv + dv + 10), 1'b1)
      waitSampling();
      // The monitor updates lowLen on the edge that sees sampling resume
      @(posedge clock);
      `CHK((lowLen >= 12 * dv) && (lowLen <= 14 * dv + 10), 1'b1)
      prevRes = expRes(v, rj);
      rdChk(ADDR_STATUS, 32'h1);
      rdChk(ADDR_RES_HI, {24'h0, prevRes[15:8]});
      rdChk(ADDR_RES_LO, {24'h0, prevRes[7:0]});
      wr(ADDR_STATUS, 32'h1);
      rdChk(ADDR_STATUS, 32'h0);
   endtask

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [31:0] rnd;
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      rdChk(ADDR_CTRL, 32'h0);
      rdChk(ADDR_TIMING, {24'h0, TIMING_RESET});
      axiWrite(8'h14, 32'hff, 4'h1, r);
      `CHK(r, RESP_SLVERR)
      axiRead(8'h14, d, r);
      `CHK({r, d}, {RESP_SLVERR, 32'h0})
      axiWrite(ADDR_TIMING, 32'hff, 4'h0, r);
      rdChk(ADDR_TIMING, 32'h0);
      wr(ADDR_CTRL, 32'h3);
      rdChk(ADDR_CTRL, 32'h1);
      waitSampling();
      // Every clock and acquisition code once; corner levels at both ends
      for (int i = 0; i < 8; i++) begin
         rnd = nextRand();
         sleepIn <= (i == 3);
         convert(3'(i), 3'((i * 3) % 8), rnd[10], (i == 0) ? 10'h000 :
            (i == 7) ? 10'h3ff : rnd[9:0]);
      end
      sleepIn <= 1'b0;
      // Abort mid-conversion keeps the old result and flag
      level <= 10'h155;
      wr(ADDR_TIMING, 32'h06);
      wr(ADDR_CTRL, 32'h3);
      repeat (100) @(posedge clock);
      wr(ADDR_CTRL, 32'h1);
      rdChk(ADDR_CTRL, 32'h1);
      prevRes = expRes(10'h3ff, 1'b0);
      rdChk(ADDR_RES_HI, {24'h0, prevRes[15:8]});
      rdChk(ADDR_STATUS, 32'h0);
      waitSampling();
      // Divided clock freezes during sleep
      sleepIn <= 1'b1;
      wr(ADDR_TIMING, 32'h80);
      wr(ADDR_CTRL, 32'h3);
      repeat (200) @(posedge clock);
      rdChk(ADDR_CTRL, 32'h3);
      sleepIn <= 1'b0;
      waitDone();
      prevRes = expRes(10'h155, 1'b1);
      rdChk(ADDR_RES_LO, {24'h0, prevRes[7:0]});
      waitSampling();
      // Reset during a conversion
      wr(ADDR_TIMING, 32'h06);
      wr(ADDR_CTRL, 32'h3);
      repeat (50) @(posedge clock);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      `CHK(sampleEn, 1'b0)
      rdChk(ADDR_CTRL, 32'h0);
      rdChk(ADDR_TIMING, 32'h0);
      prevRes = expRes(10'h155, 1'b0);
      rdChk(ADDR_RES_LO, {24'h0, prevRes[7:0]});
      final_report();
   end
endmodule
